/* File: hdl/ptl_pkg.sv */
// Constants, field positions and state codes for the bus and pin layer.
// Assumes a single free-running system clock and a synchronous reset.
// Functional notes
// RQ1: Read/write input high reads, low writes.
// RQ2: Low chip select selects; high ignores bus.
// RQ3: Outside decode gates chip select with strobes.
// RQ4: Read acknowledge only after data driven.
// RQ5: Write acknowledge only after data captured.
// RQ6: Reset clears control and direction registers.
// RQ7: System clock runs continuously, any phase.
// RQ8: Two 8-bit ports, joinable into 16 bits.
// RQ9: Handshake pins serve four selectable functions.
// RQ10: General control bits 3-0 set pin sense.
// RQ11: Status register reads live handshake levels.
// RQ12: Port C: six dual-function lines, two plain.
// RQ13: Port C direction per data-direction bit.
// RQ14: External clock mode advances on rising edge.
// RQ15: Run/halt mode runs high, holds low.
// RQ16: Timer output: interrupt request or square wave.
// RQ17: Square wave output starts high.
// RQ18: Low timer acknowledge input acknowledges interrupt.
// RQ19: Ports own separate interrupt request/acknowledge pair.
// RQ20: DMA request pulses low three clocks.
// RQ21: Five register selects choose 23 registers.
// RQ22: Register data moves over 8-bit data bus.
// RQ23: Bus and acknowledge released when deselected.
package ptl_pkg;
   // Register offsets as seen on the register selects.
   localparam logic [4:0] OFS_GEN_CTRL = 5'h00;
   localparam logic [4:0] OFS_SVC_REQ = 5'h01;
   localparam logic [4:0] OFS_A_DIR = 5'h02;
   localparam logic [4:0] OFS_B_DIR = 5'h03;
   localparam logic [4:0] OFS_C_DIR = 5'h04;
   localparam logic [4:0] OFS_PORT_VEC = 5'h05;
   localparam logic [4:0] OFS_A_CTRL = 5'h06;
   localparam logic [4:0] OFS_B_CTRL = 5'h07;
   localparam logic [4:0] OFS_A_DATA = 5'h08;
   localparam logic [4:0] OFS_B_DATA = 5'h09;
   localparam logic [4:0] OFS_A_ALT = 5'h0A;
   localparam logic [4:0] OFS_B_ALT = 5'h0B;
   localparam logic [4:0] OFS_C_DATA = 5'h0C;
   localparam logic [4:0] OFS_STATUS = 5'h0D;
   localparam logic [4:0] OFS_TMR_CTRL = 5'h10;
   localparam logic [4:0] OFS_TMR_VEC = 5'h11;
   // One bit per implemented register; the 23 set bits.
   localparam logic [31:0] REG_MAP = 32'h07BB3FFF;
   localparam logic [7:0] RST_VALUE = 8'h00;
   localparam logic [7:0] RST_VECTOR = 8'h0F;
   // General control fields.
   localparam int GC_BIDIR = 7;
   localparam int GC_WIDE = 6;
   localparam int GC_H34_EN = 5;
   localparam int GC_H12_EN = 4;
   // Service request fields.
   localparam int SR_DMA_SEL = 6;
   localparam int SR_PORT_IRQ_ACK_N_SEL = 4;
   localparam int SR_PORT_IRQ_N_SEL = 3;
   // Port A/B control: output enable bit and two-bit function code.
   localparam int HC_OUT = 5;
   localparam logic [1:0] HC_NEGATED = 2'h0;
   localparam logic [1:0] HC_ASSERTED = 2'h1;
   localparam logic [1:0] HC_INTERLOCK = 2'h2;
   localparam logic [1:0] HC_PULSED = 2'h3;
   // Timer control fields.
   localparam int TC_TIMER_OUTPUT_EN = 7;
   localparam int TC_TIMER_OUTPUT_IRQ = 6;
   localparam int TC_TIMER_IRQ_ACK_N_EN = 5;
   localparam int TC_RUN = 0;
   localparam logic [1:0] CLK_SYS = 2'h0;
   localparam logic [1:0] CLK_RUNHALT = 2'h1;
   // Port C line positions of the dual-function pins.
   localparam int PC_TIN = 2;
   localparam int PC_TIMER_OUTPUT = 3;
   localparam int PC_DMA = 4;
   localparam int PC_PORT_IRQ_N = 5;
   localparam int PC_PORT_IRQ_ACK_N = 6;
   localparam int PC_TIMER_IRQ_ACK_N = 7;
   // Pulse lengths in system clocks.
   localparam int DMA_PULSE_CYCLES = 3;
   localparam int HS_PULSE_CYCLES = 4;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACCESS = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_e;
endpackage

/* File: hdl/pulse_if.sv */
// Trigger and pulse pair between the pin layer and its pulse generators.
// Assumes both ends share the system clock.
`timescale 1ns/100ps
interface pulse_if;
   logic fire;
   logic pulse_n;
   modport gen (input fire, output pulse_n);
   modport user (output fire, input pulse_n);
endinterface

/* File: hdl/input_sync2.sv */
// Two-stage synchroniser for a vector of asynchronous pin inputs.
// Assumes the inputs change no faster than the system clock can follow.
`timescale 1ns/100ps
module input_sync2 #(
   parameter int W = 8
) (
   input wire logic clk_sys,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   // Only the second stage is ever read, to keep metastability contained.
   always_ff @(posedge clk_sys) begin
      meta_reg <= d;
      q <= meta_reg;
   end
endmodule

/* File: hdl/pulse_gen.sv */
// Fixed-length active-low pulse generator started by a one-cycle fire.
// Assumes fire is synchronous to clk_sys; fires during a pulse are ignored.
`timescale 1ns/100ps
module pulse_gen
   import ptl_pkg::*;
#(
   parameter int LEN = 3
) (
   input wire logic clk_sys,
   input wire logic srst,
   pulse_if.gen pif
);
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   assign cnt_next = (pif.fire && cnt_reg == 4'h0) ? 4'(LEN) :
                     (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
   // The pulse is low for exactly LEN clocks after the fire.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_reg <= 4'h0;
         pif.pulse_n <= 1'b1;
      end else begin
         cnt_reg <= cnt_next;
         pif.pulse_n <= (cnt_next == 4'h0);
      end
   end
endmodule

/* File: hdl/parallel_timer_bus_pin_layer.sv */
// Host bus slave, register store and pin functions of the parallel
// interface and timer. Assumes the counting, handshake sequencing and
// status logic sit in a core beside it on the same clock.
`timescale 1ns/100ps
module parallel_timer_bus_pin_layer
   import ptl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic read_write,
   input wire logic [4:0] register_select,
   input wire logic [7:0] host_data_bus_in,
   output logic [7:0] host_data_bus_out,
   output logic host_data_bus_oe_n,
   output logic transfer_ack_n,
   output logic transfer_ack_oe_n,
   input wire logic [3:0] handshake_pins_in,
   output logic [3:0] handshake_pins_out,
   output logic [3:0] handshake_pins_oe_n,
   input wire logic [7:0] port_a_lines_in,
   output logic [7:0] port_a_lines_out,
   output logic [7:0] port_a_lines_oe_n,
   input wire logic [7:0] port_b_lines_in,
   output logic [7:0] port_b_lines_out,
   output logic [7:0] port_b_lines_oe_n,
   input wire logic [7:0] port_c_lines_in,
   output logic [7:0] port_c_lines_out,
   output logic [7:0] port_c_lines_oe_n,
   input wire logic [3:0] hs_status,
   input wire logic [1:0] hs_drive_req,
   input wire logic timer_irq_req,
   input wire logic timer_zero,
   input wire logic port_irq_req,
   input wire logic dma_event,
   output logic [3:0] hs_asserted,
   output logic [3:0] hs_edge,
   output logic [3:0] status_clear,
   output logic timer_advance,
   output logic timer_irq_acked,
   output logic port_irq_acked
);
   // Every pin input passes two flip-flops before anything looks at it.
   logic cs_s;
   logic rw_s;
   logic [4:0] rs_s;
   logic [7:0] db_s;
   logic [3:0] hs_s;
   logic [7:0] pa_s;
   logic [7:0] pb_s;
   logic [7:0] pc_s;
   input_sync2 #(.W(43)) u_sync (
      .clk_sys(clk_sys),
      .d({cs_n, read_write, register_select, host_data_bus_in,
          handshake_pins_in, port_a_lines_in, port_b_lines_in,
          port_c_lines_in}),
      .q({cs_s, rw_s, rs_s, db_s, hs_s, pa_s, pb_s, pc_s})
   );

   bus_state_e state_reg;
   bus_state_e state_next;
   logic [7:0] regs_reg [0:31];
   logic [3:0] hs_prev_reg;
   logic [1:0] req_prev_reg;
   logic tin_prev_reg;
   logic square_reg;

   // Named views of the control registers.
   logic [7:0] gen_ctrl;
   logic [7:0] svc_req;
   logic [7:0] tmr_ctrl;
   logic [7:0] c_dir;
   logic [7:0] c_data;
   assign gen_ctrl = regs_reg[OFS_GEN_CTRL];
   assign svc_req = regs_reg[OFS_SVC_REQ];
   assign tmr_ctrl = regs_reg[OFS_TMR_CTRL];
   assign c_dir = regs_reg[OFS_C_DIR];
   assign c_data = regs_reg[OFS_C_DATA];

   // Dual-function selection; lines 0 and 1 have no special use.
   logic [7:0] pc_special;
   assign pc_special = {tmr_ctrl[TC_TIMER_IRQ_ACK_N_EN], svc_req[SR_PORT_IRQ_ACK_N_SEL],
                        svc_req[SR_PORT_IRQ_N_SEL], svc_req[SR_DMA_SEL],
                        tmr_ctrl[TC_TIMER_OUTPUT_EN], tmr_ctrl[2:1] != CLK_SYS,
                        2'b00}; // [RQ12]

   // Interrupt acknowledge pins count only while given that function.
   logic iack_tmr;
   logic iack_port;
   logic cycle_on;
   assign iack_tmr = pc_special[PC_TIMER_IRQ_ACK_N] & ~pc_s[PC_TIMER_IRQ_ACK_N]; // [RQ18]
   assign iack_port = pc_special[PC_PORT_IRQ_ACK_N] & ~pc_s[PC_PORT_IRQ_ACK_N]; // [RQ19]
   assign cycle_on = ~cs_s | iack_tmr | iack_port; // [RQ2]

   // An acknowledge cycle reads its vector; otherwise the selects decide.
   logic [4:0] acc_index;
   logic acc_read;
   assign acc_index = iack_tmr ? OFS_TMR_VEC :
                      iack_port ? OFS_PORT_VEC : rs_s; // [RQ21]
   assign acc_read = iack_tmr | iack_port | rw_s; // [RQ1]

   // Handshake sense: a set bit makes the pin active high.
   logic [3:0] sense;
   logic [3:0] hs_act;
   logic [3:0] hs_en;
   assign sense = gen_ctrl[3:0];
   assign hs_act = ~(hs_s ^ sense); // [RQ10]
   assign hs_en = {{2{gen_ctrl[GC_H34_EN]}}, {2{gen_ctrl[GC_H12_EN]}}};

   // Data reads show the latch for output lines and the pin for inputs.
   logic [7:0] a_drive;
   logic [7:0] b_drive;
   logic [7:0] c_drive;
   logic [7:0] a_read;
   logic [7:0] b_read;
   logic [7:0] c_read;
   logic [7:0] rd_value;
   assign a_read = (regs_reg[OFS_A_DATA] & a_drive) | (pa_s & ~a_drive);
   assign b_read = (regs_reg[OFS_B_DATA] & b_drive) | (pb_s & ~b_drive);
   assign c_read = (c_data & c_dir) | (pc_s & ~c_dir);
   assign rd_value = !REG_MAP[acc_index] ? 8'h00 :
                     acc_index == OFS_A_DATA ? a_read :
                     acc_index == OFS_B_DATA ? b_read :
                     acc_index == OFS_A_ALT ? pa_s :
                     acc_index == OFS_B_ALT ? pb_s :
                     acc_index == OFS_C_DATA ? c_read :
                     acc_index == OFS_STATUS ? {hs_s, hs_status} :
                     regs_reg[acc_index]; // [RQ11]

   // Bus cycle: take the access, then acknowledge, then wait for release.
   logic wr_strobe;
   assign wr_strobe = (state_reg == BUS_ACCESS) && !acc_read;
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         BUS_IDLE: begin
            if (cycle_on) state_next = BUS_ACCESS;
         end
         BUS_ACCESS: state_next = BUS_ACK; // [RQ4] [RQ5]
         BUS_ACK: begin
            if (!cycle_on) state_next = BUS_IDLE; // [RQ23]
         end
         default: state_next = BUS_IDLE;
      endcase
   end

   // Data is placed or captured on the edge that leaves ACCESS, and the
   // acknowledge is registered on that same edge, so it never leads data.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= BUS_IDLE;
         host_data_bus_out <= 8'h00;
         host_data_bus_oe_n <= 1'b1;
         transfer_ack_n <= 1'b1;
         transfer_ack_oe_n <= 1'b1;
      end else begin
         state_reg <= state_next;
         if (state_reg == BUS_ACCESS && acc_read) begin
            host_data_bus_out <= rd_value; // [RQ22]
            host_data_bus_oe_n <= 1'b0; // [RQ4]
         end else if (state_next == BUS_IDLE) begin
            host_data_bus_oe_n <= 1'b1; // [RQ23]
         end
         transfer_ack_n <= ~(state_next == BUS_ACK);
         transfer_ack_oe_n <= ~(state_next == BUS_ACK); // [RQ23]
      end
   end

   // Register store; reset clears all control and direction registers.
   for (genvar i = 0; i < 32; i++) begin : g_reg
      localparam logic [7:0] RV = (i == int'(OFS_PORT_VEC) ||
                                   i == int'(OFS_TMR_VEC)) ?
                                  RST_VECTOR : RST_VALUE;
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            regs_reg[i] <= RV; // [RQ6]
         end else if (wr_strobe && acc_index == 5'(i) && REG_MAP[i]) begin
            regs_reg[i] <= db_s; // [RQ5]
         end
      end
   end

   // H2 and H4 outputs follow their control field; H1 and H3 only listen.
   pulse_if hs_pif [2] ();
   logic [3:0] hs_out_next;
   logic [3:0] hs_drv_next;
   for (genvar k = 0; k < 2; k++) begin : g_hs
      logic [7:0] ctrl;
      logic [1:0] code;
      logic lvl;
      assign ctrl = regs_reg[k == 0 ? OFS_A_CTRL : OFS_B_CTRL];
      assign code = ctrl[4:3];
      assign hs_pif[k].fire = (code == HC_PULSED) & hs_drive_req[k] &
                              ~req_prev_reg[k];
      assign lvl = code == HC_NEGATED ? 1'b0 :
                   code == HC_ASSERTED ? 1'b1 :
                   code == HC_INTERLOCK ? hs_drive_req[k] :
                   ~hs_pif[k].pulse_n; // [RQ9]
      assign hs_out_next[2*k+1] = ~(lvl ^ sense[2*k+1]); // [RQ10]
      assign hs_drv_next[2*k+1] = ctrl[HC_OUT] & hs_en[2*k+1];
      assign hs_out_next[2*k] = 1'b1;
      assign hs_drv_next[2*k] = 1'b0;
      pulse_gen #(.LEN(HS_PULSE_CYCLES)) u_hs_pulse (
         .clk_sys(clk_sys),
         .srst(srst),
         .pif(hs_pif[k])
      );
   end

   // In the bidirectional modes the handshake, not the DDR, steers the
   // port; there the 16-bit mode ties port B to port A's handshake.
   logic bidir;
   logic wide;
   assign bidir = gen_ctrl[GC_BIDIR];
   assign wide = gen_ctrl[GC_WIDE];
   assign a_drive = bidir ? {8{hs_act[1]}} : regs_reg[OFS_A_DIR];
   assign b_drive = bidir ? {8{wide ? hs_act[1] : hs_act[3]}} :
                    regs_reg[OFS_B_DIR]; // [RQ8]

   // DMA request pulse, only while line 4 carries that function.
   pulse_if dma_pif ();
   assign dma_pif.fire = dma_event & svc_req[SR_DMA_SEL];
   pulse_gen #(.LEN(DMA_PULSE_CYCLES)) u_dma_pulse (
      .clk_sys(clk_sys),
      .srst(srst),
      .pif(dma_pif)
   ); // [RQ20]

   // Special-function drive; interrupt request pins are open drain, low only.
   logic timer_output_irq;
   logic [7:0] sp_out;
   logic [7:0] sp_drv;
   assign timer_output_irq = tmr_ctrl[TC_TIMER_OUTPUT_IRQ];
   assign sp_out = {2'b00, 1'b0, dma_pif.pulse_n,
                    timer_output_irq ? 1'b0 : square_reg, 3'b000}; // [RQ16]
   assign sp_drv = {2'b00, port_irq_req, 1'b1,
                    timer_output_irq ? timer_irq_req : 1'b1, 3'b000}; // [RQ19]
   assign c_drive = (pc_special & sp_drv) | (~pc_special & c_dir); // [RQ13]

   // Timer clocking from the input pin, by the clock-control field.
   logic timer_input;
   logic adv_next;
   assign timer_input = pc_s[PC_TIN];
   assign adv_next = tmr_ctrl[TC_RUN] &
                     (tmr_ctrl[2:1] == CLK_SYS ? 1'b1 :
                      tmr_ctrl[2:1] == CLK_RUNHALT ? timer_input : // [RQ15]
                      timer_input & ~tin_prev_reg); // [RQ14]

   // Square wave restarts high whenever the timer or its pin is idle.
   always_ff @(posedge clk_sys) begin
      if (srst || !tmr_ctrl[TC_RUN] || !tmr_ctrl[TC_TIMER_OUTPUT_EN]) begin
         square_reg <= 1'b1; // [RQ17]
      end else if (timer_zero) begin
         square_reg <= ~square_reg;
      end
   end

   // All port, handshake and core-facing outputs are registered here.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hs_prev_reg <= 4'h0;
         req_prev_reg <= 2'b00;
         tin_prev_reg <= 1'b0;
         handshake_pins_out <= 4'hF;
         handshake_pins_oe_n <= 4'hF;
         port_a_lines_out <= 8'h00;
         port_a_lines_oe_n <= 8'hFF;
         port_b_lines_out <= 8'h00;
         port_b_lines_oe_n <= 8'hFF;
         port_c_lines_out <= 8'h00;
         port_c_lines_oe_n <= 8'hFF;
         hs_asserted <= 4'h0;
         hs_edge <= 4'h0;
         status_clear <= 4'h0;
         timer_advance <= 1'b0;
         timer_irq_acked <= 1'b0;
         port_irq_acked <= 1'b0;
      end else begin
         hs_prev_reg <= hs_act;
         req_prev_reg <= hs_drive_req;
         tin_prev_reg <= timer_input;
         handshake_pins_out <= hs_out_next;
         handshake_pins_oe_n <= ~hs_drv_next;
         port_a_lines_out <= regs_reg[OFS_A_DATA];
         port_a_lines_oe_n <= ~a_drive;
         port_b_lines_out <= regs_reg[OFS_B_DATA];
         port_b_lines_oe_n <= ~b_drive;
         port_c_lines_out <= (pc_special & sp_out) |
                             (~pc_special & c_data);
         port_c_lines_oe_n <= ~c_drive; // [RQ12]
         hs_asserted <= hs_act & hs_en; // [RQ9]
         hs_edge <= hs_act & ~hs_prev_reg & hs_en;
         status_clear <= (wr_strobe && acc_index == OFS_STATUS) ?
                         db_s[3:0] : 4'h0;
         timer_advance <= adv_next;
         timer_irq_acked <= (state_reg == BUS_ACCESS) & iack_tmr; // [RQ18]
         port_irq_acked <= (state_reg == BUS_ACCESS) & iack_port &
                           ~iack_tmr;
      end
   end
endmodule

/* File: test/bus_pin_props.sv */
// Concurrent checks on the top-level ports of the bus and pin layer.
// Assumes a master that holds its select until it sees the acknowledge.
`timescale 1ns/100ps
module bus_pin_props
   import ptl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic read_write,
   input wire logic host_data_bus_oe_n,
   input wire logic transfer_ack_n,
   input wire logic transfer_ack_oe_n,
   input wire logic [7:0] port_a_lines_oe_n,
   input wire logic [7:0] port_c_lines_in,
   input wire logic [7:0] port_c_lines_out,
   input wire logic [7:0] port_c_lines_oe_n,
   input wire logic timer_irq_acked
);
   logic ack_low;
   logic idle;

   // The acknowledge counts only while it is really driven low.
   assign ack_low = !transfer_ack_n && !transfer_ack_oe_n;
   assign idle = cs_n && port_c_lines_in[7] && port_c_lines_in[6];

   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   AST_RESET_RELEASES: assert property (disable iff (1'b0)
      srst |=> host_data_bus_oe_n && transfer_ack_oe_n
      && (&port_c_lines_oe_n) && (&port_a_lines_oe_n))
      else $error("pins still driven after reset");
   AST_READ_DATA_FIRST: assert property (
      $rose(ack_low) && read_write |-> !host_data_bus_oe_n)
      else $error("read acknowledged without data driven");
   AST_WRITE_TAKEN: assert property (
      $rose(ack_low) && !read_write |-> host_data_bus_oe_n && $past(!cs_n, 2))
      else $error("write acknowledge without a settled select");
   AST_SELECT_ANSWERED: assert property (
      $fell(cs_n) |-> ##[2:6] ack_low)
      else $error("selected cycle got no acknowledge");
   AST_ACK_STANDS: assert property (
      $rose(ack_low) |-> ack_low [*3])
      else $error("acknowledge withdrawn too early");
   AST_DESELECT_RELEASE: assert property (
      idle [*4] |-> host_data_bus_oe_n && transfer_ack_oe_n)
      else $error("bus not released after deselect");
   AST_DMA_THREE: assert property (
      $fell(port_c_lines_out[4]) && !port_c_lines_oe_n[4]
      |-> !port_c_lines_out[4] [*3] ##1 port_c_lines_out[4])
      else $error("dma request pulse not three cycles");
   AST_TACK_ANSWERED: assert property (
      timer_irq_acked |-> ##[0:3] ack_low)
      else $error("timer acknowledge not answered");
   AST_TACK_SINGLE: assert property (
      timer_irq_acked |=> !timer_irq_acked)
      else $error("timer acknowledge pulse too long");
endmodule

bind parallel_timer_bus_pin_layer bus_pin_props props (
   .clk_sys(clk_sys), .srst(srst), .cs_n(cs_n), .read_write(read_write),
   .host_data_bus_oe_n(host_data_bus_oe_n), .transfer_ack_n(transfer_ack_n),
   .transfer_ack_oe_n(transfer_ack_oe_n),
   .port_a_lines_oe_n(port_a_lines_oe_n), .port_c_lines_in(port_c_lines_in),
   .port_c_lines_out(port_c_lines_out), .port_c_lines_oe_n(port_c_lines_oe_n),
   .timer_irq_acked(timer_irq_acked));

/* File: test/host_bus_model.sv */
// Behavioural bus master facing the host bus of the pin layer.
// Assumes one free-running clock; its signals change on the falling edge.
`timescale 1ns/100ps
module host_bus_model (
   input wire logic clk_sys,
   output logic cs_n = 1'b1,
   output logic read_write = 1'b1,
   output logic [4:0] register_select = 5'h00,
   output logic iack_n = 1'b1,
   output logic [7:0] host_data_bus_in,
   input wire logic [7:0] host_data_bus_out,
   input wire logic host_data_bus_oe_n,
   input wire logic transfer_ack_n,
   input wire logic transfer_ack_oe_n
);
   logic drive = 1'b0;
   logic [7:0] wdat = 8'h00;
   logic [7:0] float_pat = 8'hA5;
   logic ack_seen;

   // A released data bus has no pull-up, so it wanders every cycle.
   always @(negedge clk_sys) float_pat <= ~float_pat;
   assign ack_seen = transfer_ack_oe_n ? 1'b1 : transfer_ack_n;
   assign host_data_bus_in = !host_data_bus_oe_n ? host_data_bus_out :
      (drive ? wdat : float_pat);

   // One whole bus or acknowledge cycle, held until the answer is seen or 24 clocks pass.
   task automatic cycle(input logic rw, input logic ack_cyc,
      input logic [4:0] sel, input logic [7:0] wd,
      output logic [7:0] rd, output bit ok);
      int n;
      @(negedge clk_sys);
      read_write = rw;
      register_select = sel;
      wdat = wd;
      drive = !rw;
      if (ack_cyc) begin
         iack_n = 1'b0;
      end else begin
         cs_n = 1'b0;
      end
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack_seen !== 1'b0 && n < 24);
      rd = host_data_bus_in;
      ok = (n < 24);
      @(negedge clk_sys);
      cs_n = 1'b1;
      iack_n = 1'b1;
      drive = 1'b0;
      // Deselect must be seen for four clocks before the next cycle.
      repeat (4) @(negedge clk_sys);
   endtask
endmodule

/* File: test/parallel_timer_bus_pin_layer_test.sv */
// Self-checking bench for the bus and pin layer with a reference model.
// Assumes the host bus model and the bound checker are compiled with it.
`timescale 1ns/100ps
module parallel_timer_bus_pin_layer_test
   import ptl_pkg::*;
;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic dma_event = 1'b0;
   logic cs_n, read_write, iack_n, bus_oe_n, ack_n, ack_oe_n, t_acked, t_adv;
   logic [4:0] register_select;
   logic [5:0] c_rnd = 6'h00;
   logic [7:0] pa_in = 8'h00, pb_in = 8'h00;
   logic [7:0] bus_in, bus_out, pc_in, pc_out, pc_oe_n, pa_oe_n, rd, v;
   logic [3:0] hs_in = 4'h0, hs_st = 4'h0;
   logic [3:0] hs_as, a, tin_h = 4'h0;
   int err_total = 0, cmp_count = 0, seed = 60761, acks = 0, n;
   int ref_reg [32];
   bit ok;
   localparam logic [4:0] WL [8] = '{5'h02, 5'h03, 5'h04, 5'h11, 5'h13,
      5'h0E, 5'h12, 5'h1F};

   assign pc_in = {iack_n, 1'b1, c_rnd};
   parallel_timer_bus_pin_layer dut (
      .clk_sys(clk_sys), .srst(srst), .cs_n(cs_n), .read_write(read_write),
      .register_select(register_select), .host_data_bus_in(bus_in),
      .host_data_bus_out(bus_out), .host_data_bus_oe_n(bus_oe_n),
      .transfer_ack_n(ack_n), .transfer_ack_oe_n(ack_oe_n),
      .handshake_pins_in(hs_in), .handshake_pins_out(),
      .handshake_pins_oe_n(), .port_a_lines_in(pa_in), .port_a_lines_out(),
      .port_a_lines_oe_n(pa_oe_n), .port_b_lines_in(pb_in),
      .port_b_lines_out(), .port_b_lines_oe_n(), .port_c_lines_in(pc_in),
      .port_c_lines_out(pc_out),
      .port_c_lines_oe_n(pc_oe_n), .hs_status(hs_st), .hs_drive_req(2'h0),
      .timer_irq_req(1'b0), .timer_zero(1'b0), .port_irq_req(1'b0),
      .dma_event(dma_event), .hs_asserted(hs_as), .hs_edge(),
      .status_clear(), .timer_advance(t_adv), .timer_irq_acked(t_acked),
      .port_irq_acked());
   host_bus_model hm (.clk_sys, .cs_n, .read_write, .register_select,
      .iack_n, .host_data_bus_in(bus_in), .host_data_bus_out(bus_out),
      .host_data_bus_oe_n(bus_oe_n), .transfer_ack_n(ack_n),
      .transfer_ack_oe_n(ack_oe_n));

   // The clock never stops, as the layer relies on it throughout.
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   // Port lines wander at random; the timer acknowledge line stays with the master, the port one is held high.
   always @(negedge clk_sys) begin
      pa_in <= 8'($random(seed));
      pb_in <= 8'($random(seed));
      c_rnd <= 6'($random(seed));
   end
   // Counts acknowledge pulses and keeps the timer pin as the layer sees it.
   always @(posedge clk_sys) begin
      if (t_acked === 1'b1) acks <= acks + 1;
      tin_h <= {tin_h[2:0], pc_in[PC_TIN]};
   end

   task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict;
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [4:0] adr, input logic [7:0] d);
      hm.cycle(1'b0, 1'b0, adr, d, rd, ok);
      chk("write ack", 8'h01, {7'h00, ok});
      if (REG_MAP[adr]) ref_reg[adr] = d;
   endtask

   task automatic rd_chk(input logic [4:0] adr);
      hm.cycle(1'b1, 1'b0, adr, 8'h00, rd, ok);
      chk("read ack", 8'h01, {7'h00, ok});
      chk("read data", 8'(ref_reg[adr]), rd);
   endtask

   // Reset clears the model too; only the vectors come back as 0F.
   task automatic do_reset(input int cycles);
      srst = 1'b1;
      repeat (cycles) @(negedge clk_sys);
      srst = 1'b0;
      foreach (ref_reg[i]) ref_reg[i] = 0;
      ref_reg[OFS_PORT_VEC] = RST_VECTOR;
      ref_reg[OFS_TMR_VEC] = RST_VECTOR;
   endtask

   // Port data, status and live timer places are skipped here.
   task automatic check_all;
      for (int i = 0; i < 32; i++) begin
         if (!(i inside {[8:13], [23:26]})) rd_chk(5'(i));
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      give_verdict();
   end

   initial begin
      do_reset(20);
      check_all();
      // Mapped places keep what is written, unmapped ones stay zero.
      foreach (WL[i]) wr(WL[i], 8'($random(seed)));
      foreach (WL[i]) rd_chk(WL[i]);
      repeat (4) @(negedge clk_sys);
      chk("c dir", ~8'(ref_reg[OFS_C_DIR]), pc_oe_n);
      chk("a dir", ~8'(ref_reg[OFS_A_DIR]), pa_oe_n);
      // Status shows the live pin levels over the core status bits.
      repeat (4) begin
         hs_in = 4'($random(seed));
         hs_st = 4'($random(seed));
         repeat (4) @(negedge clk_sys);
         ref_reg[OFS_STATUS] = {hs_in, hs_st};
         rd_chk(OFS_STATUS);
      end
      // Flipping every sense bit must flip every asserted level.
      repeat (2) begin
         v = 8'($random(seed));
         wr(OFS_GEN_CTRL, {4'h3, v[3:0]});
         repeat (4) @(negedge clk_sys);
         a = hs_as;
         wr(OFS_GEN_CTRL, {4'h3, ~v[3:0]});
         repeat (4) @(negedge clk_sys);
         chk("sense flip", 8'h0F, {4'h0, a ^ hs_as});
      end
      wr(OFS_SVC_REQ, 8'h58);
      repeat (4) @(negedge clk_sys);
      dma_event = 1'b1;
      @(negedge clk_sys);
      dma_event = 1'b0;
      n = 0;
      repeat (12) @(posedge clk_sys) n += int'(pc_oe_n[4] === 1'b0
         && pc_out[4] === 1'b0);
      chk("dma low cycles", 8'h03, 8'(n));
      // Timer acknowledge returns the vector with a single pulse.
      wr(OFS_TMR_CTRL, 8'hA0);
      // A stopped timer drives its square-wave pin high.
      v = 8'({pc_oe_n[PC_TIMER_OUTPUT], pc_out[PC_TIMER_OUTPUT]});
      chk("square start", 8'h01, v);
      wr(OFS_TMR_VEC, 8'($random(seed)));
      hm.cycle(1'b1, 1'b1, 5'h00, 8'h00, rd, ok);
      chk("ack answered", 8'h01, {7'h00, ok});
      chk("ack vector", 8'(ref_reg[OFS_TMR_VEC]), rd);
      chk("ack pulses", 8'h01, 8'(acks));
      // Run/halt follows the pin level; external clock counts its rises.
      wr(OFS_TMR_CTRL, 8'hA3);
      repeat (8) @(posedge clk_sys)
         chk("run halt", 8'(tin_h[2]), 8'(t_adv));
      wr(OFS_TMR_CTRL, 8'hA5);
      repeat (8) @(posedge clk_sys)
         chk("ext clock", 8'(tin_h[2] & ~tin_h[3]), 8'(t_adv));
      v = ~8'(ref_reg[OFS_C_DIR]);
      chk("plain c", {6'h00, v[1:0]}, {6'h00, pc_oe_n[1:0]});
      // A second reset in mid-run clears all but the vectors once more.
      do_reset(2);
      check_all();
      give_verdict();
   end
endmodule
